// >>> dv/hold_props.sv
`timescale 1ns/1ps
// ***
// status checks
// ***
module hold_props (
  // clock and reset
  input wire        clock,
  input wire        reset,
  // detector and host inputs
  input wire        main_supply_ok,
  input wire        control_supply_ok,
  input wire        fault_detected,
  input wire        supply_low_fault,
  input wire        caution_detected,
  input wire        hardwired_output_block,
  input wire        hold_time_write,
  input wire [15:0] hold_time_data,
  // status outputs
  input wire        fault_output,
  input wire        caution_output,
  input wire        drive_ready,
  input wire        motor_powered,
  input wire        hold_expired,
  input wire [15:0] hold_time_setting
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence back_s; main_supply_ok [*2]; endsequence
  a_fault_open: assert property (fault_detected |=> !fault_output) else $error("fault closed");
  a_fault_stop: assert property (fault_detected |=> !drive_ready && !motor_powered)
    else $error("run on fault");
  a_caution_on: assert property (caution_detected && !fault_detected && !supply_low_fault
    && control_supply_ok |=> caution_output) else $error("no caution");
  a_caution_off: assert property (!caution_detected |=> !caution_output) else $error("caution");
  a_ready_cause: assert property (drive_ready |-> $past(!hardwired_output_block && !fault_detected))
    else $error("bad ready");
  a_expiry_stop: assert property (hold_expired && !main_supply_ok && !$past(main_supply_ok)
    |=> !drive_ready && !motor_powered)
    else $error("run past hold");
  a_recover_clear: assert property (back_s |=> !hold_expired) else $error("expiry stuck");
  a_set_range: assert property (hold_time_setting >= 16'h0014 && hold_time_setting <= 16'hC350)
    else $error("setting range");
  a_set_write: assert property (hold_time_write && hold_time_data >= 16'h0014 && hold_time_data <= 16'hC350
    |=> ##[0:1] hold_time_setting == $past(hold_time_data)) else $error("setting lost");
  a_ctrl_loss: assert property (!control_supply_ok |=> !fault_output && !drive_ready)
    else $error("ctrl loss");
  a_low_stop: assert property (supply_low_fault |=> !motor_powered) else $error("low supply run");
endmodule // hold_props
bind power_interruption_hold_supervisor hold_props u_props (
  .clock                  (clock),
  .reset                  (reset),
  .main_supply_ok         (main_supply_ok),
  .control_supply_ok      (control_supply_ok),
  .fault_detected         (fault_detected),
  .supply_low_fault       (supply_low_fault),
  .caution_detected       (caution_detected),
  .hardwired_output_block (hardwired_output_block),
  .hold_time_write        (hold_time_write),
  .hold_time_data         (hold_time_data),
  .fault_output           (fault_output),
  .caution_output         (caution_output),
  .drive_ready            (drive_ready),
  .motor_powered          (motor_powered),
  .hold_expired           (hold_expired),
  .hold_time_setting      (hold_time_setting)
);

// >>> dv/power_interruption_hold_supervisor_tb.sv
`timescale 1ns/1ps
module power_interruption_hold_supervisor_tb;
  reg clock = 0, reset = 1, grid_ok = 1, control_supply_ok = 1, fault_detected = 0, supply_low_fault = 0;
  reg caution_detected = 0, hardwired_output_block = 0, polarity_sensor_fitted = 1, polarity_done = 0;
  reg enable_cmd = 1, hold_time_write = 0, e_rdy;
  reg [15:0] hold_time_data = 16'h0000;
  wire main_supply_ok, fault_output, caution_output, drive_ready, motor_powered, hold_expired;
  wire [15:0] hold_time_setting;
  integer n_errors = 0, checks_done = 0, seed = 52796, i;
  initial forever #20 clock = ~clock;
  supply_cutoff u_cut (.grid_ok(grid_ok), .fault_output(fault_output), .main_supply_ok(main_supply_ok));
  // short ms keeps the hold walk brief
  power_interruption_hold_supervisor #(
    .CYCLES_PER_MS (10)
  ) u_dut (
    .clock                  (clock),
    .reset                  (reset),
    .main_supply_ok         (main_supply_ok),
    .control_supply_ok      (control_supply_ok),
    .fault_detected         (fault_detected),
    .supply_low_fault       (supply_low_fault),
    .caution_detected       (caution_detected),
    .hardwired_output_block (hardwired_output_block),
    .polarity_sensor_fitted (polarity_sensor_fitted),
    .polarity_done          (polarity_done),
    .enable_cmd             (enable_cmd),
    .hold_time_write        (hold_time_write),
    .hold_time_data         (hold_time_data),
    .fault_output           (fault_output),
    .caution_output         (caution_output),
    .drive_ready            (drive_ready),
    .motor_powered          (motor_powered),
    .hold_expired           (hold_expired),
    .hold_time_setting      (hold_time_setting)
  );
  task chk(input [15:0] e, input [15:0] a);
    begin
      checks_done = checks_done + 1;
      if (a !== e) begin
        n_errors = n_errors + 1;
        $display("Error %0t exp %h got %h", $time, e, a);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task wr(input [15:0] d);
    begin
      hold_time_write = 1;
      hold_time_data = d;
      @(negedge clock) hold_time_write = 0;
      repeat (2) @(negedge clock);
      chk(d < 20 ? 20 : d > 50000 ? 50000 : d, hold_time_setting);
    end
  endtask
  initial begin
    #(40*3000) n_errors = n_errors + 1;
    report_and_stop;
  end
  initial begin
    repeat (20) @(negedge clock);
    reset = 0;
    @(negedge clock);
    chk(16'h0014, hold_time_setting);
    for (i = 0; i < 6; i = i + 1) wr($random(seed));
    wr(16'h0014);
    for (i = 0; i < 300; i = i + 1) begin
      {fault_detected, caution_detected, hardwired_output_block, polarity_done, enable_cmd, polarity_sensor_fitted}
        = $random(seed);
      @(negedge clock);
      e_rdy = !fault_detected & !hardwired_output_block & (polarity_sensor_fitted | polarity_done);
      chk(e_rdy, drive_ready);
      chk(!fault_detected, fault_output);
      chk(caution_detected & !fault_detected, caution_output);
      chk(e_rdy & enable_cmd, motor_powered);
    end
    {fault_detected, caution_detected, hardwired_output_block, enable_cmd} = 4'b0001;
    polarity_sensor_fitted = 1;
    // let a cut left by the last random fault heal before timing a fresh loss
    repeat (4) @(negedge clock);
    for (i = 0; i < 2; i = i + 1) begin
      grid_ok = 0;
      repeat (200 + 60 * i) @(negedge clock);
      chk(i, hold_expired);
      chk(!i, motor_powered);
      grid_ok = 1;
      repeat (4) @(negedge clock);
      chk(1, motor_powered);
    end
    control_supply_ok = 0;
    @(negedge clock) control_supply_ok = 1;
    chk(0, fault_output | drive_ready);
    // supply-low fault inside a hold must stop the motor at once
    grid_ok = 0;
    repeat (4) @(negedge clock) supply_low_fault = 1;
    @(negedge clock) supply_low_fault = 0;
    chk(0, motor_powered);
    grid_ok = 1;
    repeat (3) @(negedge clock);
    chk(1, motor_powered);
    report_and_stop;
  end
endmodule // power_interruption_hold_supervisor_tb

// >>> dv/supply_cutoff.sv
`timescale 1ns/1ps
// ***
// supply cutoff relay
// ***
module supply_cutoff (
  input  wire grid_ok,
  input  wire fault_output,
  output wire main_supply_ok
);
  // an open fault contact drops the main supply
  assign main_supply_ok = grid_ok & fault_output;
endmodule // supply_cutoff

// >>> hw/hold_supervisor_defs.vh
`ifndef HOLD_SUPERVISOR_DEFS_VH
`define HOLD_SUPERVISOR_DEFS_VH

// ****************************************
// timing
// ****************************************
`define CLOCK_HZ           25000000
`define MS_PER_SECOND      1000
`define CYCLES_PER_MS      (`CLOCK_HZ / `MS_PER_SECOND)

// ****************************************
// hold time setting, in 1 ms steps
// ****************************************
`define HOLD_WIDTH         16
`define HOLD_MIN           16'h0014
`define HOLD_MAX           16'hC350
`define HOLD_RESET         16'h0014

`endif

// >>> hw/ms_tick.v
`timescale 1ns/1ps
`include "hold_supervisor_defs.vh"

// one-cycle pulse every millisecond while run is high; restarts when run falls
module ms_tick #(
  parameter CYCLES = `CYCLES_PER_MS
) (
  // clock and reset
  input  wire clock,
  input  wire reset,
  // control
  input  wire run,
  output reg  tick_q
);

  localparam CW = 16;
  // the divider holds at most 65536 cycles per millisecond; the cut below is on purpose
  localparam integer  LAST_INT = CYCLES - 1;
  localparam [CW-1:0] LAST     = LAST_INT[CW-1:0];

  reg [CW-1:0] count_q;

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      count_q <= 16'h0000;
      tick_q  <= 1'b0;
    end else if (!run) begin
      count_q <= 16'h0000;
      tick_q  <= 1'b0;
    end else if (count_q == LAST) begin
      count_q <= 16'h0000;
      tick_q  <= 1'b1;
    end else begin
      count_q <= count_q + 16'h0001;
      tick_q  <= 1'b0;
    end
  end

endmodule // ms_tick

// >>> hw/power_interruption_hold_supervisor.v
// How it works
// - fault output closed normally, open on error
// - fault forces immediate stop; caution does not
// - caution output closed on caution, open while fault is pending
// - ready output closed without regard to enable
// - ready needs supply, no block, no fault, polarity
// - keep motor powered during hold time in ms
// - hold setting 20..50000, default 20, immediate
// - short interruption keeps motor enabled
// - long interruption stops motor power
// - long interruption clears ready and disables motor
// - motor power resumes when main supply returns
// - control supply loss opens all contacts but caution
// - supply-low fault ignores hold time
`timescale 1ns/1ps
`include "hold_supervisor_defs.vh"

module power_interruption_hold_supervisor #(
  parameter CYCLES_PER_MS = `CYCLES_PER_MS,
  parameter HOLD_WIDTH    = `HOLD_WIDTH
) (
  // clock and reset
  input  wire                  clock,
  input  wire                  reset,
  // detectors inside the drive
  input  wire                  main_supply_ok,
  input  wire                  control_supply_ok,
  input  wire                  fault_detected,
  input  wire                  supply_low_fault,
  input  wire                  caution_detected,
  input  wire                  hardwired_output_block,
  input  wire                  polarity_sensor_fitted,
  input  wire                  polarity_done,
  // host controller
  input  wire                  enable_cmd,
  input  wire                  hold_time_write,
  input  wire [HOLD_WIDTH-1:0] hold_time_data,
  // status outputs, high means contact closed
  output reg                   fault_output,
  output reg                   caution_output,
  output reg                   drive_ready,
  output reg                   motor_powered,
  output reg                   hold_expired,
  output reg  [HOLD_WIDTH-1:0] hold_time_setting
);

  // ****************************************
  // hold time setting
  // ****************************************
  // out-of-range writes are clamped rather than dropped, so the timer never runs
  // with a value the drive cannot honour
  wire [HOLD_WIDTH-1:0] hold_min  = `HOLD_MIN;
  wire [HOLD_WIDTH-1:0] hold_max  = `HOLD_MAX;
  wire                  below_min = (hold_time_data < hold_min);
  wire                  above_max = (hold_time_data > hold_max);
  reg  [HOLD_WIDTH-1:0] hold_time_setting_d;

  always @* begin
    if (below_min) begin
      hold_time_setting_d = hold_min;
    end else if (above_max) begin
      hold_time_setting_d = hold_max;
    end else begin
      hold_time_setting_d = hold_time_data;
    end
  end

  // a write lands on the next edge and is used by the timer from then on
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      hold_time_setting <= `HOLD_RESET;
    end else if (hold_time_write) begin
      hold_time_setting <= hold_time_setting_d;
    end
  end

  // ****************************************
  // interruption timer
  // ****************************************
  // the millisecond divider restarts with every loss, so each interruption is
  // timed from its own start and never inherits a partial millisecond
  wire                supply_lost = !main_supply_ok;
  wire                ms_pulse;
  wire                count_full;
  wire                past_setting;
  reg  [HOLD_WIDTH:0] lost_ms_q;
  reg  [HOLD_WIDTH:0] lost_ms_d;
  reg                 expired_q;
  reg                 expired_d;

  ms_tick #(
    .CYCLES (CYCLES_PER_MS)
  ) u_ms_tick (
    .clock  (clock),
    .reset  (reset),
    .run    (supply_lost),
    .tick_q (ms_pulse)
  );

  // the extra top bit lets the count pass the largest setting; it then stops
  // there rather than wrapping back below the setting
  assign count_full   = lost_ms_q[HOLD_WIDTH];
  // setting compared live, so a new value takes effect at once
  assign past_setting = (lost_ms_q > {1'b0, hold_time_setting});

  always @* begin
    if (!supply_lost) begin
      lost_ms_d = {(HOLD_WIDTH+1){1'b0}};
    end else if (ms_pulse && !count_full) begin
      lost_ms_d = lost_ms_q + {{HOLD_WIDTH{1'b0}}, 1'b1};
    end else begin
      lost_ms_d = lost_ms_q;
    end
  end

  // expiry is sticky for the rest of the interruption, even if the setting is
  // raised afterwards; only a returning supply clears it
  always @* begin
    if (!supply_lost) begin
      expired_d = 1'b0;
    end else if (past_setting) begin
      expired_d = 1'b1;
    end else begin
      expired_d = expired_q;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      lost_ms_q <= {(HOLD_WIDTH+1){1'b0}};
      expired_q <= 1'b0;
    end else begin
      lost_ms_q <= lost_ms_d;
      expired_q <= expired_d;
    end
  end

  // ****************************************
  // readiness conditions
  // ****************************************
  // caution is only reported, while control supply gates fault, ready and motor below; nothing here lets caution stop the motor
  wire any_fault   = fault_detected | supply_low_fault;
  wire in_hold     = supply_lost & !expired_q;
  wire supply_held = main_supply_ok | in_hold;
  wire block_clear = !hardwired_output_block;
  wire fault_clear = !any_fault;
  wire polarity_ok = polarity_sensor_fitted | polarity_done;
  reg  fault_output_d;
  reg  caution_output_d;
  reg  drive_ready_d;
  reg  motor_powered_d;

  // a dead control supply opens the fault, ready and motor contacts; the caution contact still follows caution_detected
  always @* begin
    fault_output_d = control_supply_ok & fault_clear;
  end

  always @* begin
    caution_output_d = caution_detected & fault_clear;
  end

  always @* begin
    drive_ready_d = supply_held & block_clear & fault_clear & polarity_ok & control_supply_ok;
  end

  // dropping the host enable cuts the motor at once, whatever the hold state
  always @* begin
    motor_powered_d = drive_ready_d & enable_cmd;
  end

  // ****************************************
  // status contacts
  // ****************************************
  // every contact is a flop of its own, so a pin never glitches while the
  // detectors settle
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      fault_output <= 1'b0;
    end else begin
      fault_output <= fault_output_d;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      caution_output <= 1'b0;
    end else begin
      caution_output <= caution_output_d;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      drive_ready <= 1'b0;
    end else begin
      drive_ready <= drive_ready_d;
    end
  end

  // ****************************************
  // motor power and expiry status
  // ****************************************
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      motor_powered <= 1'b0;
    end else begin
      motor_powered <= motor_powered_d;
    end
  end

  // the expiry flag trails expired_q by one flop, so it drops a cycle after
  // the ready contact has already closed again on a returning supply
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      hold_expired <= 1'b0;
    end else begin
      hold_expired <= expired_q;
    end
  end

endmodule // power_interruption_hold_supervisor
